// ===== gpio_regs.vh
// Register map, field positions and reset values of the dual GPIO port block.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the register index.
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// Register indices
`define IDX_PORT_A_PINS        10'h005
`define IDX_PORT_B_PINS        10'h006
`define IDX_INTERRUPT_CONTROL  10'h00B
`define IDX_ANALOG_SELECT      10'h01F
`define IDX_TIMER_PULLUP_OPT   10'h081
`define IDX_PORT_A_DIRECTION   10'h085
`define IDX_PORT_B_DIRECTION   10'h086

// Field positions
`define OPT_PULLUP_DISABLE_N   7
`define ICR_CHANGE_FLAG        0
`define ICR_CHANGE_ENABLE      3
`define PA_OPEN_DRAIN_BIT      4
`define PB_EXT_IRQ_BIT         0
`define PB_PROG_CLK_BIT        6
`define PB_PROG_DATA_BIT       7

// Widths
`define PA_W                   5
`define PB_W                   8

// Reset values
`define OPT_RESET              8'hFF
`define PA_DIR_RESET           5'h1F
`define PB_DIR_RESET           8'hFF
`define ICR_RESET              8'h00
`define ANALOG_SEL_RESET       4'h0

// Bus responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// ===== pin_sync.v
// Three-stage pin input synchroniser with agreement filter.
// Assumes pins are asynchronous to aclk; output moves only when stages 2 and 3 agree.
`default_nettype none

module pin_sync #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Pins and result
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] level
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer     i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_r  <= {W{1'b0}};
         s2_r  <= {W{1'b0}};
         s3_r  <= {W{1'b0}};
         level <= {W{1'b0}};
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Per bit, so a bouncing pin does not hold back its neighbours
         for (i = 0; i < W; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               level[i] <= s3_r[i];
            end
         end
      end
   end

endmodule // pin_sync

`default_nettype wire

// ===== change_detect.v
// Interrupt-on-change for the upper four port B pins: snapshot and sticky flag.
// Assumes synchronised pin levels; snapshot loads on every port B read and on port B writes with lane 0 on.
`default_nettype none

module change_detect (
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Pins and direction
   input  wire [3:0] pins_hi,
   input  wire [3:0] dir_hi,
   // Control
   input  wire       snap_load,
   input  wire       flag_clr,
   // Status
   output reg        flag,
   output wire       mismatch
);

   reg [3:0] snap_r;

   // Output bits drop out of the comparison [RQ7] [RQ8]
   assign mismatch = |((pins_hi ^ snap_r) & dir_hi);

   always @(posedge aclk) begin
      if (!aresetn) begin
         snap_r <= 4'h0;
         flag   <= 1'b0;
      end else begin
         if (snap_load) begin
            snap_r <= pins_hi; // [RQ21]
         end
         // Set wins over clear; a persisting mismatch keeps setting [RQ10]
         // A pin edge in the snapshot cycle may be absorbed silently [RQ11]
         if (mismatch && !snap_load) begin
            flag <= 1'b1; // [RQ8]
         end else if (flag_clr) begin
            flag <= 1'b0;
         end
      end
   end

endmodule // change_detect

`default_nettype wire

// ===== gpio_port.v
// Dual GPIO port: 5-bit port A, 8-bit port B, pull-ups and change interrupt.
// Assumes an AXI4-Lite master on aclk and board pins resolved by the bench from oe.
//
// Behaviour
// (RQ1) Direction 1 floats the pin; direction 0 drives the output latch.
// (RQ2) Port data read returns pin levels; write updates only the latch.
// (RQ3) Writes are read-modify-write: input bits latch the sampled pin level.
// (RQ4) Clearing option bit 7 enables all port B weak pull-ups together.
// (RQ5) A port B pin set as output has its pull-up off.
// (RQ6) Option register resets to all ones, pull-ups disabled.
// (RQ7) Only upper port B input bits take part in change comparison.
// (RQ8) Mismatches against last-read snapshot are ORed into flag bit 0.
// (RQ9) Port B change interrupt can wake the device from sleep.
// (RQ10) Mismatch keeps setting flag; port access then flag clear ends it.
// (RQ11) A change coinciding with a port B read may miss the flag.
// (RQ12) Software should not poll port B while using change interrupt.
// (RQ13) Unimplemented port A data and direction bits read zero.
// (RQ14) Port B direction resets to ones; its latch is not reset.
// (RQ15) Port A bit 4 is open drain and doubles as timer clock.
// (RQ16) Port B bit 0 doubles as external interrupt input.
// (RQ17) Port B bits 6 and 7 double as programming clock and data.
// (RQ18) Board must not drive a pin the device actively drives.
// (RQ19) Port A direction resets to all inputs.
// (RQ20) Port A pins selected as comparator inputs read zero.
// (RQ21) Every port B read or write reloads the change snapshot. A port B write with lane 0 off does not reload it here.
`default_nettype none
`include "gpio_regs.vh"

module gpio_port (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Port A pins
   input  wire [4:0]  port_a_in,
   output wire [4:0]  port_a_out,
   output wire [4:0]  port_a_oe,
   // Port B pins
   input  wire [7:0]  port_b_in,
   output wire [7:0]  port_b_out,
   output wire [7:0]  port_b_oe,
   output wire [7:0]  port_b_pullup_en,
   // Alternate pin functions
   output wire        timer_clock_level,
   output wire        external_irq_level,
   output wire        prog_clock_level,
   output wire        prog_data_level,
   // Core status
   input  wire        sleep_mode,
   output wire        change_irq,
   output wire        wake_req
);

   // Index of a word address; misaligned addresses never decode
   function [10:0] reg_index;
      input [11:0] addr;
      begin
         reg_index = (addr[1:0] == 2'b00) ? {1'b0, addr[11:2]} : 11'h7FF;
      end
   endfunction

   // Read-modify-write merge: input bits take the sampled pin level
   function [7:0] rmw_merge;
      input [7:0] wdata;
      input [7:0] pins;
      input [7:0] dir;
      begin
         rmw_merge = (wdata & ~dir) | (pins & dir);
      end
   endfunction

   // Register state
   reg [7:0]       opt_r;
   reg [4:0]       pa_dir_r;
   reg [7:0]       pb_dir_r;
   reg [4:0]       pa_latch_r;
   reg [7:0]       pb_latch_r;
   reg             change_en_r;
   reg [3:0]       analog_sel_r;

   // Write channel holding registers
   reg             aw_full_r;
   reg [11:0]      aw_addr_r;
   reg             w_full_r;
   reg [7:0]       w_data_r;
   reg             w_lane0_r;

   // Synchronised pin levels
   wire [4:0]      pa_level;
   wire [7:0]      pb_level;
   wire            change_flag;
   wire            change_mismatch;

   // Access decode
   wire            wr_go;
   wire [10:0]     wr_idx;
   wire            wr_en;
   wire            ar_go;
   wire [10:0]     rd_idx;
   wire            pb_read;
   wire            pb_write;
   wire            flag_clr;
   wire [4:0]      pa_read_val;
   wire [7:0]      pa_merged;
   reg  [7:0]      rd_val;
   reg             rd_hit;
   reg             wr_hit;

   pin_sync #(
      .W       (`PA_W)
   ) u_sync_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (port_a_in),
      .level   (pa_level)
   );

   pin_sync #(
      .W       (`PB_W)
   ) u_sync_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (port_b_in),
      .level   (pb_level)
   );

   // Write handshake: address and data are taken in either order
   assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
   assign wr_go         = aw_full_r && w_full_r && !s_axi_bvalid;
   assign wr_idx        = reg_index(aw_addr_r);
   // Lane 0 holds the whole register; the other strobes carry nothing
   assign wr_en         = wr_go && w_lane0_r;

   // Read handshake: one read in flight, answer one cycle after address
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_go         = s_axi_arvalid && !s_axi_rvalid;
   assign rd_idx        = reg_index(s_axi_araddr);

   // Port B reads, and port B writes with lane 0 on, reload the change snapshot [RQ21] [RQ10]
   assign pb_read  = ar_go && (rd_idx == {1'b0, `IDX_PORT_B_PINS});
   assign pb_write = wr_en && (wr_idx == {1'b0, `IDX_PORT_B_PINS});

   // Flag bit written as zero clears it; writing one cannot set it
   assign flag_clr = wr_en && (wr_idx == {1'b0, `IDX_INTERRUPT_CONTROL})
                     && !w_data_r[`ICR_CHANGE_FLAG];

   change_detect u_change (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pins_hi   (pb_level[7:4]),
      .dir_hi    (pb_dir_r[7:4]),
      .snap_load (pb_read || pb_write),
      .flag_clr  (flag_clr),
      .flag      (change_flag),
      .mismatch  (change_mismatch)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full_r <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r  <= 1'b0;
         w_data_r  <= 8'h00;
         w_lane0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_r  <= 1'b1;
         w_data_r  <= s_axi_wdata[7:0];
         w_lane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_full_r <= 1'b0;
      end
   end

   // Write decode; a write with lane 0 off is answered but stores nothing
   always @* begin
      case (wr_idx)
         {1'b0, `IDX_PORT_A_PINS},
         {1'b0, `IDX_PORT_B_PINS},
         {1'b0, `IDX_INTERRUPT_CONTROL},
         {1'b0, `IDX_ANALOG_SELECT},
         {1'b0, `IDX_TIMER_PULLUP_OPT},
         {1'b0, `IDX_PORT_A_DIRECTION},
         {1'b0, `IDX_PORT_B_DIRECTION}: wr_hit = 1'b1;
         default:                       wr_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers under reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         opt_r        <= `OPT_RESET;        // [RQ6]
         pa_dir_r     <= `PA_DIR_RESET;     // [RQ19]
         pb_dir_r     <= `PB_DIR_RESET;     // [RQ14]
         change_en_r  <= 1'b0;
         analog_sel_r <= `ANALOG_SEL_RESET;
      end else if (wr_en) begin
         case (wr_idx)
            {1'b0, `IDX_TIMER_PULLUP_OPT}: begin
               opt_r <= w_data_r;
            end
            {1'b0, `IDX_PORT_A_DIRECTION}: begin
               pa_dir_r <= w_data_r[4:0];
            end
            {1'b0, `IDX_PORT_B_DIRECTION}: begin
               pb_dir_r <= w_data_r;
            end
            {1'b0, `IDX_INTERRUPT_CONTROL}: begin
               change_en_r <= w_data_r[`ICR_CHANGE_ENABLE];
            end
            {1'b0, `IDX_ANALOG_SELECT}: begin
               analog_sel_r <= w_data_r[3:0];
            end
            default: begin
               change_en_r <= change_en_r;
            end
         endcase
      end
   end

   // Port A merges at byte width; the three unused top bits are cut below
   assign pa_merged = rmw_merge({3'b000, w_data_r[4:0]},
                                {3'b000, pa_read_val},
                                {3'b000, pa_dir_r}); // [RQ3]

   // Data latches are not reset: contents survive any reset
   // Write lands in the latch only, merged with sampled pins [RQ2] [RQ3]
   always @(posedge aclk) begin
      if (wr_en && (wr_idx == {1'b0, `IDX_PORT_A_PINS})) begin
         pa_latch_r <= pa_merged[4:0]; // [RQ3]
      end
      if (pb_write) begin
         pb_latch_r <= rmw_merge(w_data_r, pb_level, pb_dir_r); // [RQ3] [RQ14]
      end
   end

   // Comparator-selected pins read zero through the data register [RQ20]
   assign pa_read_val = pa_level & ~{1'b0, analog_sel_r};

   // Read mux; upper bits stay zero [RQ13]
   always @* begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      case (rd_idx)
         {1'b0, `IDX_PORT_A_PINS}:       rd_val = {3'b000, pa_read_val}; // [RQ2]
         {1'b0, `IDX_PORT_B_PINS}:       rd_val = pb_level;              // [RQ2]
         {1'b0, `IDX_TIMER_PULLUP_OPT}:  rd_val = opt_r;
         {1'b0, `IDX_PORT_A_DIRECTION}:  rd_val = {3'b000, pa_dir_r};    // [RQ13]
         {1'b0, `IDX_PORT_B_DIRECTION}:  rd_val = pb_dir_r;
         {1'b0, `IDX_ANALOG_SELECT}:     rd_val = {4'h0, analog_sel_r};
         {1'b0, `IDX_INTERRUPT_CONTROL}: begin
            rd_val[`ICR_CHANGE_FLAG]   = change_flag;
            rd_val[`ICR_CHANGE_ENABLE] = change_en_r;
         end
         default:                        rd_hit = 1'b0;
      endcase
   end

   // Read data is taken at the accepting edge; pin reads lag the pins by the filter
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (ar_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_val};
         s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Port A drivers; bit 4 only pulls low, never drives high [RQ1] [RQ15]
   // A floating pin shows zero, so a latch unknown since power-up stays hidden
   assign port_a_out = {1'b0, pa_latch_r[3:0] & ~pa_dir_r[3:0]};
   assign port_a_oe  = {~pa_dir_r[4] & ~pa_latch_r[4], ~pa_dir_r[3:0]}; // [RQ1] [RQ15]

   // Port B drivers; a floating output is parked low [RQ1]
   assign port_b_out = pb_latch_r & ~pb_dir_r;
   assign port_b_oe  = ~pb_dir_r; // [RQ1]

   // Global enable, then per-pin cut-off for outputs [RQ4] [RQ5]
   assign port_b_pullup_en = {`PB_W{~opt_r[`OPT_PULLUP_DISABLE_N]}} & pb_dir_r;

   // Alternate functions see the filtered pin level; the filter stands in for
   // the hysteresis buffers, at the cost of four cycles of latency
   assign timer_clock_level  = pa_level[`PA_OPEN_DRAIN_BIT];  // [RQ15]
   assign external_irq_level = pb_level[`PB_EXT_IRQ_BIT];     // [RQ16]
   assign prog_clock_level   = pb_level[`PB_PROG_CLK_BIT];    // [RQ17]
   assign prog_data_level    = pb_level[`PB_PROG_DATA_BIT];   // [RQ17]

   // Wake ignores the clock gating of the core: the flag, its enable bit and sleep_mode decide [RQ9]
   assign change_irq = change_flag & change_en_r;
   assign wake_req   = sleep_mode & change_irq; // [RQ9]

endmodule // gpio_port

`default_nettype wire

// ===== gpio_port_props.sv
// Checker for gpio_port: bus handshakes, pin drive and pull-up relations.
// Sees only the top-level ports; bound to every gpio_port instance.
`default_nettype none
module gpio_port_props (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Pins and status
   input wire logic [4:0]  port_a_out,
   input wire logic [4:0]  port_a_oe,
   input wire logic [7:0]  port_b_out,
   input wire logic [7:0]  port_b_oe,
   input wire logic [7:0]  port_b_pullup_en,
   input wire logic        sleep_mode,
   input wire logic        change_irq,
   input wire logic        wake_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_pu_off; (port_b_pullup_en & port_b_oe) == 8'h00; endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up on driven pin");
   property p_rst; $rose(aresetn) |-> {port_a_oe, port_b_oe, port_b_pullup_en} == 21'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("pins not floating after reset");
   property p_od; port_a_out[4] == 1'h0; endproperty
   a_od: assert property (p_od) else $error("open-drain pin driven high");
   property p_float;
      (port_b_out & ~port_b_oe) == 8'h00 && (port_a_out & ~port_a_oe) == 5'h0;
   endproperty
   a_float: assert property (p_float) else $error("floating pin shows data");
   property p_wake; wake_req == (sleep_mode && change_irq); endproperty
   a_wake: assert property (p_wake) else $error("wake request wrong");
   property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_ar: assert property (p_ar) else $error("read not answered");
   property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready; endproperty
   a_rhi: assert property (p_rhi) else $error("read data high bits set");
   property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdrop: assert property (p_rdrop) else $error("read answer repeated");
   property p_bbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
   c_irq: cover property (change_irq);
   c_wake: cover property (wake_req);
   c_pu: cover property (|port_b_pullup_en);
endmodule // gpio_port_props
bind gpio_port gpio_port_props gpio_port_props_inst (.*);
`default_nettype wire

// ===== gpio_board.sv
// Board model: resolves each pin from device drive, board drive and pull-ups.
// Assumes the bench never drives a pin whose output enable is high.
`default_nettype none
module gpio_board (
   // Clock
   input  wire logic       aclk,
   // Device drive
   input  wire logic [4:0] port_a_out,
   input  wire logic [4:0] port_a_oe,
   input  wire logic [7:0] port_b_out,
   input  wire logic [7:0] port_b_oe,
   input  wire logic [7:0] port_b_pullup_en,
   // Board drive
   input  wire logic [4:0] a_drv,
   input  wire logic [4:0] a_en,
   input  wire logic [7:0] b_drv,
   input  wire logic [7:0] b_en,
   // Pin levels
   output var  logic [4:0] port_a_in,
   output var  logic [7:0] port_b_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tgl = 1'h0;
   // An undriven pin wanders so a stale level never passes for a real one
   always @(posedge aclk) tgl <= ~tgl;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         // Device drive wins; board drive is kept off such pins
         port_b_in[i] = port_b_oe[i] ? port_b_out[i] : b_en[i] ? b_drv[i]
                        : port_b_pullup_en[i] | (tgl ^ i[0]);
         if (i < 5) port_a_in[i] = port_a_oe[i] ? port_a_out[i] : a_en[i] ? a_drv[i] : tgl;
      end
   end
endmodule // gpio_board
`default_nettype wire

// ===== testbench.sv
// Bench for gpio_port: AXI4-Lite register tasks and scenario tasks.
// Assumes gpio_board resolves the pins; bready and rready stay high.
`default_nettype none
`include "gpio_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] OK = 2'h0;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
   logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, sleep_mode = '0;
   logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  port_a_in, port_a_out, port_a_oe, a_drv = '0, a_en = '0;
   logic [7:0]  port_b_in, port_b_out, port_b_oe, port_b_pullup_en, b_drv = '0, b_en = '0;
   logic        change_irq, wake_req, timer_clock_level, external_irq_level;
   logic        prog_clock_level, prog_data_level;
   int          n_errors = 0;
   int          checked = 0;
   gpio_port gpio_port_inst (.*);
   gpio_board gpio_board_inst (.*);
   always #5 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wc(input logic [9:0] i, input logic [7:0] v, input logic [1:0] e);
      bit aw = 1;
      bit w = 1;
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk($sformatf("bresp %h", i), e, s_axi_bresp);
   endtask
   task automatic rc(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk($sformatf("rdata %h", i), {24'h0, e}, s_axi_rdata);
      chk($sformatf("rresp %h", i), er, s_axi_rresp);
   endtask
   task automatic t_reset;
      rc(`IDX_TIMER_PULLUP_OPT, 8'hFF, OK);
      rc(`IDX_PORT_A_DIRECTION, 8'h1F, OK);
      rc(`IDX_PORT_B_DIRECTION, 8'hFF, OK);
      chk("oe", 13'h0, {port_a_oe, port_b_oe});
      chk("pullup", 8'h00, port_b_pullup_en);
      rc(10'h3FF, 8'h00, 2'h2);
      wc(10'h3FF, 8'h55, 2'h2);
   endtask
   task automatic t_port_b;
      b_drv <= 8'hA5;
      b_en <= 8'hFF;
      wt(4);
      wc(`IDX_PORT_B_PINS, 8'h3C, OK);
      b_en <= 8'hF0;
      wc(`IDX_PORT_B_DIRECTION, 8'hF0, OK);
      chk("b oe", 8'h0F, port_b_oe);
      chk("b out", 8'h05, port_b_out);
      wt(4);
      rc(`IDX_PORT_B_PINS, 8'hA5, OK);
      chk("alt b", 32'h5, {prog_data_level, prog_clock_level, external_irq_level});
      wc(`IDX_PORT_B_PINS, 8'h0C, OK);
      wt(4);
      rc(`IDX_PORT_B_PINS, 8'hAC, OK);
   endtask
   task automatic t_port_a;
      wc(`IDX_PORT_A_DIRECTION, 8'hE0, OK);
      rc(`IDX_PORT_A_DIRECTION, 8'h00, OK);
      wc(`IDX_PORT_A_PINS, 8'h1A, OK);
      chk("a oe", 5'h0F, port_a_oe);
      chk("a out", 5'h0A, port_a_out);
      wc(`IDX_PORT_A_PINS, 8'h05, OK);
      chk("a oe", 5'h1F, port_a_oe);
      wt(4);
      rc(`IDX_PORT_A_PINS, 8'h05, OK);
      chk("tclk", 1'h0, timer_clock_level);
      wc(`IDX_ANALOG_SELECT, 8'h0F, OK);
      rc(`IDX_PORT_A_PINS, 8'h00, OK);
   endtask
   task automatic t_change;
      wc(`IDX_TIMER_PULLUP_OPT, 8'h7F, OK);
      chk("pullup", 8'hF0, port_b_pullup_en);
      wc(`IDX_INTERRUPT_CONTROL, 8'h08, OK);
      b_en <= 8'h70;
      wc(`IDX_PORT_B_DIRECTION, 8'h70, OK);
      chk("pullup", 8'h70, port_b_pullup_en);
      wc(`IDX_PORT_B_PINS, 8'h0C, OK);
      wt(5); // Waiting, never polling the port
      wc(`IDX_INTERRUPT_CONTROL, 8'h08, OK);
      chk("irq", 1'h0, change_irq);
      b_drv <= 8'hB5;
      wt(7); // Three filter stages, agreement, then the flag edge
      chk("irq", 1'h1, change_irq);
      rc(`IDX_INTERRUPT_CONTROL, 8'h09, OK);
      sleep_mode <= 1'h1;
      wt(1);
      chk("wake", 1'h1, wake_req);
      wc(`IDX_INTERRUPT_CONTROL, 8'h08, OK);
      chk("irq", 1'h1, change_irq);
      rc(`IDX_PORT_B_PINS, 8'h3C, OK);
      wc(`IDX_INTERRUPT_CONTROL, 8'h08, OK);
      chk("irq", 1'h0, change_irq);
      b_drv <= 8'hA5;
      wt(5);
      wc(`IDX_PORT_B_PINS, 8'h0C, OK);
      wc(`IDX_INTERRUPT_CONTROL, 8'h08, OK);
      chk("irq", 1'h0, change_irq);
   endtask
   task automatic t_reset2;
      aresetn <= 1'h0;
      wt(2);
      aresetn <= 1'h1;
      chk("pullup", 8'h00, port_b_pullup_en);
      rc(`IDX_PORT_B_DIRECTION, 8'hFF, OK);
      wc(`IDX_PORT_B_DIRECTION, 8'hF0, OK);
      chk("b out", 8'h0C, port_b_out); // Latch kept over reset
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      wt(5);
      aresetn <= 1'h1;
      t_reset;
      t_port_b;
      t_port_a;
      t_change;
      t_reset2;
      close_out;
   end
   initial begin
      wt(20000);
      n_errors++;
      close_out;
   end
endmodule // testbench
`default_nettype wire
